// ===== pio_ports.sv
// pio_ports.sv: three parallel ports with latches, read paths and bus mode
// assumes cpu strobes are one-cycle pulses synchronous to sys_clk_in
`timescale 1ns/1ps
`include "pio_cfg.svh"

module pio_ports #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [WIDTH-1:0] sfr_wdata_in,
	input wire logic wr_latch_in,
	input wire logic rd_latch_in,
	input wire logic rd_pin_in,
	output logic [WIDTH-1:0] sfr_rdata_out,
	input wire logic ext_access_in,
	input wire logic ext_drive_in,
	input wire logic [WIDTH-1:0] ext_addr_data_in,
	input wire logic [WIDTH-1:0] ext_addr_mid_in,
	input wire logic [WIDTH-1:0] ext_addr_high_in,
	input wire logic ext_high_sel_in,
	input wire logic [WIDTH-1:0] first_periph_en_in,
	input wire logic [WIDTH-1:0] first_periph_data_in,
	input wire logic [WIDTH-1:0] first_periph_oe_in,
	input wire logic [WIDTH-1:0] third_periph_en_in,
	input wire logic [WIDTH-1:0] third_periph_data_in,
	input wire logic [WIDTH-1:0] third_periph_oe_in,
	input wire logic [WIDTH-1:0] first_pin_in,
	output logic [WIDTH-1:0] first_pin_out,
	output logic [WIDTH-1:0] first_pin_oe_out,
	input wire logic [WIDTH-1:0] second_pin_in,
	output logic [WIDTH-1:0] second_analog_sel_out,
	output logic [WIDTH-1:0] second_digital_in_out,
	input wire logic [WIDTH-1:0] third_pin_in,
	output logic [WIDTH-1:0] third_pin_out,
	output logic [WIDTH-1:0] third_pin_oe_out,
	output logic [WIDTH-1:0] third_pullup_en_out
);
	pio_pkg::pio_sel_e sel;
	logic [WIDTH-1:0] first_port_latch;
	logic [WIDTH-1:0] second_port_config;
	logic [WIDTH-1:0] third_port_latch;
	logic [WIDTH-1:0] third_bus_data;
	logic [WIDTH-1:0] rdata_d;
	logic [WIDTH-1:0] rdata_q;

	// address decode; unmapped addresses select nothing
	always_comb
	begin
		unique case (sfr_addr_in)
			`PIO_ADDR_FIRST: sel = pio_pkg::PIO_SEL_FIRST;
			`PIO_ADDR_SECOND: sel = pio_pkg::PIO_SEL_SECOND;
			`PIO_ADDR_THIRD: sel = pio_pkg::PIO_SEL_THIRD;
			default: sel = pio_pkg::PIO_SEL_NONE;
		endcase
	end

	// first port latch, forced to ones by external accesses
	pio_bit_latch #(
		.WIDTH(WIDTH),
		.RESET_VAL(WIDTH'(`PIO_RST_FIRST))
	) u_first_latch (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.wr_in(wr_latch_in && sel == pio_pkg::PIO_SEL_FIRST),
		.data_in(sfr_wdata_in),
		.force_ones_in(ext_access_in),
		.q_out(first_port_latch)
	);

	// second port config; one means analog, zero means digital input
	pio_bit_latch #(
		.WIDTH(WIDTH),
		.RESET_VAL(WIDTH'(`PIO_RST_SECOND))
	) u_second_cfg (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.wr_in(wr_latch_in && sel == pio_pkg::PIO_SEL_SECOND),
		.data_in(sfr_wdata_in),
		.force_ones_in(1'b0),
		.q_out(second_port_config)
	);

	// third port latch; left alone by external accesses
	pio_bit_latch #(
		.WIDTH(WIDTH),
		.RESET_VAL(WIDTH'(`PIO_RST_THIRD))
	) u_third_latch (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.wr_in(wr_latch_in && sel == pio_pkg::PIO_SEL_THIRD),
		.data_in(sfr_wdata_in),
		.force_ones_in(1'b0),
		.q_out(third_port_latch)
	);

	// first port: push-pull bus when external, else open-drain
	pio_pin_ctrl #(
		.WIDTH(WIDTH)
	) u_first_pins (
		.latch_in(first_port_latch),
		.bus_mode_in(ext_access_in),
		.bus_data_in(ext_addr_data_in),
		.bus_drive_in(ext_drive_in),
		.periph_en_in(first_periph_en_in),
		.periph_data_in(first_periph_data_in),
		.periph_oe_in(first_periph_oe_in),
		.pin_out(first_pin_out),
		.pin_oe_out(first_pin_oe_out)
	);

	// middle or high address byte on the third port
	assign third_bus_data = ext_high_sel_in ? ext_addr_high_in : ext_addr_mid_in;

	pio_pin_ctrl #(
		.WIDTH(WIDTH)
	) u_third_pins (
		.latch_in(third_port_latch),
		.bus_mode_in(ext_access_in),
		.bus_data_in(third_bus_data),
		.bus_drive_in(1'b1),
		.periph_en_in(third_periph_en_in),
		.periph_data_in(third_periph_data_in),
		.periph_oe_in(third_periph_oe_in),
		.pin_out(third_pin_out),
		.pin_oe_out(third_pin_oe_out)
	);

	// pull-up stays on while the latch holds one and no peripheral owns the pin, in port or bus mode
	assign third_pullup_en_out = ~third_periph_en_in & third_port_latch;

	// second port never drives; it only steers the input mux
	assign second_analog_sel_out = second_port_config;
	assign second_digital_in_out = ~second_port_config & second_pin_in;

	// read path: latch strobe returns latches, pin strobe returns pins
	always_comb
	begin
		rdata_d = '0;
		if (rd_latch_in)
		begin
			unique case (sel)
				pio_pkg::PIO_SEL_FIRST: rdata_d = first_port_latch;
				pio_pkg::PIO_SEL_SECOND: rdata_d = second_port_config;
				pio_pkg::PIO_SEL_THIRD: rdata_d = third_port_latch;
				pio_pkg::PIO_SEL_NONE: rdata_d = '0;
			endcase
		end
		else if (rd_pin_in)
		begin
			unique case (sel)
				pio_pkg::PIO_SEL_FIRST: rdata_d = first_pin_in;
				// analog-selected bits read zero, having no digital buffer
				pio_pkg::PIO_SEL_SECOND: rdata_d = second_digital_in_out;
				pio_pkg::PIO_SEL_THIRD: rdata_d = third_pin_in;
				pio_pkg::PIO_SEL_NONE: rdata_d = '0;
			endcase
		end
	end

	// registered read data, holds until the next read
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_q <= '0;
		else if (rd_latch_in || rd_pin_in)
			rdata_q <= rdata_d;
	end
	assign sfr_rdata_out = rdata_q;

	// an external access leaves all first latches at one next cycle
	first_force_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ext_access_in
		|=> first_port_latch == `PIO_ALL_ONES)
		else $error("first latch not forced to ones");
	// a write without external access loads the bus value
	first_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_latch_in && sfr_addr_in == `PIO_ADDR_FIRST && !ext_access_in
		|=> first_port_latch == $past(sfr_wdata_in))
		else $error("first latch write lost");
	// third latch is never forced, so every write to it lands
	third_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_latch_in && sfr_addr_in == `PIO_ADDR_THIRD
		|=> third_port_latch == $past(sfr_wdata_in))
		else $error("third latch write lost");
	// second port config write takes effect the next cycle
	second_cfg_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_latch_in && sfr_addr_in == `PIO_ADDR_SECOND
		|=> second_analog_sel_out == $past(sfr_wdata_in))
		else $error("second port config not loaded");
	// a stray address must not alias onto any port register
	unmapped_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_latch_in && sel == pio_pkg::PIO_SEL_NONE && !ext_access_in
		|=> $stable(first_port_latch) && $stable(second_port_config)
		&& $stable(third_port_latch))
		else $error("unmapped write changed a register");
	// latch read returns the latch one cycle later
	latch_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		rd_latch_in && sfr_addr_in == `PIO_ADDR_THIRD
		|=> sfr_rdata_out == $past(third_port_latch))
		else $error("latch read mismatch");
	// read-modify-write path wins even if the pin strobe is up too
	first_latch_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		rd_latch_in && sfr_addr_in == `PIO_ADDR_FIRST
		|=> sfr_rdata_out == $past(first_port_latch))
		else $error("first latch read mismatch");
	// config reads back through the latch path
	cfg_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		rd_latch_in && sfr_addr_in == `PIO_ADDR_SECOND
		|=> sfr_rdata_out == $past(second_port_config))
		else $error("config read mismatch");
	// pin read returns the pin level one cycle later
	pin_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		rd_pin_in && !rd_latch_in && sfr_addr_in == `PIO_ADDR_FIRST
		|=> sfr_rdata_out == $past(first_pin_in))
		else $error("pin read mismatch");
	// third port pin read sees the pad, not the latch
	third_pin_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		rd_pin_in && !rd_latch_in && sfr_addr_in == `PIO_ADDR_THIRD
		|=> sfr_rdata_out == $past(third_pin_in))
		else $error("third pin read mismatch");
	// only digital-selected second port bits carry their pin level
	digital_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		rd_pin_in && !rd_latch_in && sfr_addr_in == `PIO_ADDR_SECOND
		|=> sfr_rdata_out == $past(second_pin_in & ~second_port_config))
		else $error("digital input read mismatch");
	// unmapped reads return zero rather than a stale port
	unmapped_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(rd_latch_in || rd_pin_in) && sel == pio_pkg::PIO_SEL_NONE
		|=> sfr_rdata_out == '0)
		else $error("unmapped read not zero");
	// read data holds while no read strobe is up
	rdata_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!rd_latch_in && !rd_pin_in
		|=> $stable(sfr_rdata_out))
		else $error("read data changed without a read");
	// bus mode with drive high drives address and data push-pull
	bus_drive_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ext_access_in && ext_drive_in && first_periph_en_in == '0
		|-> first_pin_oe_out == '1 && first_pin_out == ext_addr_data_in)
		else $error("first port not push-pull in bus mode");
	// bus mode with drive low releases the pins for incoming data
	first_release_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ext_access_in && !ext_drive_in && first_periph_en_in == '0
		|-> first_pin_oe_out == '0)
		else $error("first port not released for data in");
	// port mode: latch one floats, latch zero drives low
	open_drain_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!ext_access_in && first_periph_en_in == '0
		|-> first_pin_oe_out == ~first_port_latch && first_pin_out == '0)
		else $error("open-drain behaviour broken");
	// port mode: third port drives low exactly where the latch is zero
	third_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!ext_access_in && third_periph_en_in == '0
		|-> third_pin_oe_out == ~third_port_latch && third_pin_out == '0)
		else $error("third port low drive broken");
	// address bytes on the third port during external access
	third_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ext_access_in && third_periph_en_in == '0
		|-> third_pin_out == (ext_high_sel_in ? ext_addr_high_in : ext_addr_mid_in))
		else $error("third port address byte wrong");
	// address bytes are driven on every third port pin
	third_push_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ext_access_in && third_periph_en_in == '0
		|-> third_pin_oe_out == '1)
		else $error("third port not driven in bus mode");
	// port mode: pull-up on for latch ones, never fighting a low drive
	pullup_excl_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!ext_access_in
		|-> (third_pullup_en_out & third_pin_oe_out) == '0
		&& (third_port_latch & ~third_periph_en_in & ~third_pullup_en_out) == '0)
		else $error("third port pull-up wrong");
	// an enabled peripheral owns its first port pins outright
	first_periph_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		((first_pin_oe_out ^ first_periph_oe_in) & first_periph_en_in) == '0
		&& ((first_pin_out ^ first_periph_data_in) & first_periph_en_in) == '0)
		else $error("first port pin not handed to peripheral");
	// an enabled peripheral owns its third port pins outright
	third_periph_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		((third_pin_oe_out ^ third_periph_oe_in) & third_periph_en_in) == '0
		&& ((third_pin_out ^ third_periph_data_in) & third_periph_en_in) == '0)
		else $error("third port pin not handed to peripheral");
	// external accesses leave the third latch untouched
	third_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		ext_access_in && !wr_latch_in
		|=> $stable(third_port_latch))
		else $error("third latch disturbed by external access");
	// first edge after reset still shows every reset value
	reset_value_a: assert property (@(posedge sys_clk_in)
		$rose(rst_n_in) |-> first_port_latch == `PIO_RST_FIRST
		&& second_port_config == `PIO_RST_SECOND && third_port_latch == `PIO_RST_THIRD)
		else $error("registers not at reset values");
endmodule // pio_ports

// ===== pio_cfg.svh
// pio_cfg.svh: addresses, reset values and widths for the parallel port block
// assumes an 8-bit special-function-register address space on the cpu side
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

`define PIO_ADDR_W 8
`define PIO_DATA_W 8
`define PIO_ADDR_FIRST 8'h80
`define PIO_ADDR_SECOND 8'h90
`define PIO_ADDR_THIRD 8'ha0
`define PIO_RST_FIRST 8'hff
`define PIO_RST_SECOND 8'hff
`define PIO_RST_THIRD 8'hff
`define PIO_ALL_ONES 8'hff

`endif

// ===== pio_pkg.sv
// pio_pkg.sv: types shared by the parallel port block
// assumes pio_cfg.svh supplies the numeric constants
package pio_pkg;
	typedef logic [7:0] pio_byte_t;
	// which port a register access selects
	typedef enum logic [1:0]
	{
		PIO_SEL_NONE = 2'b00,
		PIO_SEL_FIRST = 2'b01,
		PIO_SEL_SECOND = 2'b10,
		PIO_SEL_THIRD = 2'b11
	} pio_sel_e;
endpackage

// ===== pio_bit_latch.sv
// pio_bit_latch.sv: one port's bank of d-type bit latches
// assumes the write strobe is a one-cycle pulse on sys_clk_in
`timescale 1ns/1ps
`include "pio_cfg.svh"

module pio_bit_latch #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic wr_in,
	input wire logic [WIDTH-1:0] data_in,
	input wire logic force_ones_in,
	output logic [WIDTH-1:0] q_out
);
	// forced ones win over a cpu write in the same cycle
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			q_out <= RESET_VAL;
		else if (force_ones_in)
			q_out <= '1;
		else if (wr_in)
			q_out <= data_in;
	end
endmodule // pio_bit_latch

// ===== pio_pin_ctrl.sv
// pio_pin_ctrl.sv: output driver control of one pin group
// assumes the pad outside resolves enable and pull-ups
`timescale 1ns/1ps

module pio_pin_ctrl #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] latch_in,
	input wire logic bus_mode_in,
	input wire logic [WIDTH-1:0] bus_data_in,
	input wire logic bus_drive_in,
	input wire logic [WIDTH-1:0] periph_en_in,
	input wire logic [WIDTH-1:0] periph_data_in,
	input wire logic [WIDTH-1:0] periph_oe_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_out
);
	// bus drives push-pull; port mode only pulls low; peripheral owns its pins
	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
		begin
			if (periph_en_in[i])
			begin
				pin_out[i] = periph_data_in[i];
				pin_oe_out[i] = periph_oe_in[i];
			end
			else if (bus_mode_in)
			begin
				pin_out[i] = bus_data_in[i];
				pin_oe_out[i] = bus_drive_in;
			end
			else
			begin
				pin_out[i] = 1'b0;
				pin_oe_out[i] = ~latch_in[i];
			end
		end
	end
endmodule // pio_pin_ctrl

// ===== pio_ext_model.sv
// pio_ext_model.sv: board resistors and external devices on the first and third port pins
// assumes a design oe bit high means the pad drives its pin_out bit
`timescale 1ns/1ps

module pio_ext_model (
	input wire logic clk_in,
	input wire logic [7:0] first_out_in,
	input wire logic [7:0] first_oe_in,
	input wire logic [7:0] third_out_in,
	input wire logic [7:0] third_oe_in,
	input wire logic [7:0] third_pullup_in,
	input wire logic [7:0] dev_en_in,
	input wire logic [7:0] dev_val_in,
	output logic [7:0] first_lvl_out,
	output logic [7:0] third_lvl_out
);
	logic tog_q = 1'b0;

	// an unpulled, undriven node wanders so a stale level is never read back as valid
	always @(posedge clk_in)
		tog_q <= ~tog_q;

	// pad drive wins, then an external device, then the resistors
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			// board pull-ups on the open-drain first port
			first_lvl_out[i] = first_oe_in[i] ? first_out_in[i] :
				(dev_en_in[i] ? dev_val_in[i] : 1'b1);
			third_lvl_out[i] = third_oe_in[i] ? third_out_in[i] :
				(dev_en_in[i] ? dev_val_in[i] : (third_pullup_in[i] ? 1'b1 : tog_q));
		end
	end
endmodule // pio_ext_model

// ===== tb_top.sv
// tb_top.sv: register-level tests of the three parallel ports
// assumes pio_ports, pio_ext_model and pio_cfg.svh are compiled alongside
`timescale 1ns/1ps
`include "pio_cfg.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_top;
	logic sys_clk_in = 1'b0;
	logic rst_n_in, wr, rdl, rdp, ext_acc, ext_drv, hi_sel;
	logic [7:0] addr, wdata, rdata, ext_ad, ext_mid, ext_hi, f_en, f_dat, f_oe, t_en, t_dat;
	logic [7:0] t_oe, f_lvl, f_out, f_oe_o, s_pin, s_ana, s_dig, t_lvl, t_out, t_oe_o, t_pu;
	logic [7:0] dev_en, dev_val;
	int n_mismatch = 0;
	int total_checks = 0;

	pio_ports dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sfr_addr_in(addr),
		.sfr_wdata_in(wdata), .wr_latch_in(wr), .rd_latch_in(rdl), .rd_pin_in(rdp),
		.sfr_rdata_out(rdata), .ext_access_in(ext_acc), .ext_drive_in(ext_drv),
		.ext_addr_data_in(ext_ad), .ext_addr_mid_in(ext_mid), .ext_addr_high_in(ext_hi),
		.ext_high_sel_in(hi_sel), .first_periph_en_in(f_en), .first_periph_data_in(f_dat),
		.first_periph_oe_in(f_oe), .third_periph_en_in(t_en), .third_periph_data_in(t_dat),
		.third_periph_oe_in(t_oe), .first_pin_in(f_lvl), .first_pin_out(f_out),
		.first_pin_oe_out(f_oe_o), .second_pin_in(s_pin), .second_analog_sel_out(s_ana),
		.second_digital_in_out(s_dig), .third_pin_in(t_lvl), .third_pin_out(t_out),
		.third_pin_oe_out(t_oe_o), .third_pullup_en_out(t_pu));

	pio_ext_model ext (.clk_in(sys_clk_in), .first_out_in(f_out), .first_oe_in(f_oe_o),
		.third_out_in(t_out), .third_oe_in(t_oe_o), .third_pullup_in(t_pu),
		.dev_en_in(dev_en), .dev_val_in(dev_val), .first_lvl_out(f_lvl),
		.third_lvl_out(t_lvl));

	// 200 MHz core clock
	initial
		forever #2.5 sys_clk_in = ~sys_clk_in;

	// single end point for both normal finish and watchdog
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// one-cycle write strobe, driven at the falling edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge sys_clk_in);
		wr = 1'b0;
	endtask

	// read data is registered, so it is settled one falling edge later
	task automatic rd_reg(input logic [7:0] a, input logic use_latch, input logic [7:0] exp);
		@(negedge sys_clk_in);
		addr = a;
		rdl = use_latch;
		rdp = ~use_latch;
		@(negedge sys_clk_in);
		rdl = 1'b0;
		rdp = 1'b0;
		`CHK(rdata, exp)
	endtask

	// a whole run is some 53 cycles; this leaves ample margin
	initial
	begin
		#20000;
		n_mismatch++;
		wrap_up();
	end

	initial
	begin
		{rst_n_in, wr, rdl, rdp, ext_acc, ext_drv, hi_sel} = 7'h00;
		{addr, wdata, ext_ad, ext_mid, ext_hi, f_en, f_dat, f_oe} = 64'h0;
		{t_en, t_dat, t_oe, dev_en, dev_val} = 40'h0;
		s_pin = 8'hff;
		repeat (10) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		`CHK(f_oe_o, 8'h00)
		`CHK(s_ana, 8'hff)
		`CHK(t_pu, 8'hff)
		rd_reg(`PIO_ADDR_FIRST, 1'b1, 8'hff);
		rd_reg(`PIO_ADDR_THIRD, 1'b1, 8'hff);
		rd_reg(`PIO_ADDR_SECOND, 1'b1, 8'hff);
		// first port: low nibble released, one of them pulled down outside
		wr_reg(`PIO_ADDR_FIRST, 8'h0f);
		`CHK(f_oe_o, 8'hf0)
		`CHK(f_out & f_oe_o, 8'h00)
		dev_en = 8'h01;
		rd_reg(`PIO_ADDR_FIRST, 1'b0, 8'h0e);
		rd_reg(`PIO_ADDR_FIRST, 1'b1, 8'h0f);
		dev_en = 8'h00;
		// second port: input only, per-bit analog or digital
		wr_reg(`PIO_ADDR_SECOND, 8'h5a);
		`CHK(s_ana, 8'h5a)
		`CHK(s_dig, 8'ha5)
		rd_reg(`PIO_ADDR_SECOND, 1'b1, 8'h5a);
		// digital bits follow their pins, analog bits read zero
		s_pin = 8'h0f;
		#1 `CHK(s_dig, 8'h05)
		rd_reg(`PIO_ADDR_SECOND, 1'b0, 8'h05);
		// third port: zeros drive low, ones pulled high
		wr_reg(`PIO_ADDR_THIRD, 8'h3c);
		`CHK(t_oe_o, 8'hc3)
		`CHK(t_pu & 8'h3c, 8'h3c)
		rd_reg(`PIO_ADDR_THIRD, 1'b0, 8'h3c);
		// unmapped address must leave the first port latch alone
		wr_reg(8'h88, 8'h00);
		rd_reg(`PIO_ADDR_FIRST, 1'b1, 8'h0f);
		rd_reg(8'h88, 1'b1, 8'h00);
		// external access with a competing first-port write
		@(negedge sys_clk_in);
		{ext_acc, ext_drv, ext_ad, ext_mid, ext_hi} = {2'b11, 24'ha51234};
		{addr, wdata, wr} = {`PIO_ADDR_FIRST, 8'h00, 1'b1};
		@(negedge sys_clk_in);
		wr = 1'b0;
		`CHK(f_oe_o, 8'hff)
		`CHK(f_lvl, 8'ha5)
		`CHK(t_lvl, 8'h12)
		hi_sel = 1'b1;
		#1 `CHK(t_lvl, 8'h34)
		@(negedge sys_clk_in);
		ext_drv = 1'b0;
		#1 `CHK(f_oe_o, 8'h00)
		`CHK(f_lvl, 8'hff)
		@(negedge sys_clk_in);
		{ext_acc, hi_sel} = 2'b00;
		rd_reg(`PIO_ADDR_FIRST, 1'b1, 8'hff);
		`CHK(f_oe_o, 8'h00)
		// peripherals take single pins over from the latches
		{f_en, f_dat, f_oe} = {8'h01, 8'h00, 8'h01};
		{t_en, t_dat, t_oe} = {8'h80, 8'h80, 8'h80};
		#1 `CHK(f_lvl, 8'hfe)
		`CHK(t_lvl, 8'hbc)
		rd_reg(`PIO_ADDR_FIRST, 1'b1, 8'hff);
		// mid-run reset must bring back the second and third port power-on values
		@(negedge sys_clk_in);
		{f_en, t_en} = 16'h0;
		rst_n_in = 1'b0;
		repeat (2) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		`CHK(t_oe_o, 8'h00)
		`CHK(t_pu, 8'hff)
		`CHK(s_ana, 8'hff)
		rd_reg(`PIO_ADDR_THIRD, 1'b1, 8'hff);
		rd_reg(`PIO_ADDR_SECOND, 1'b1, 8'hff);
		wrap_up();
	end
endmodule // tb_top
